/* File: hdl/plac_top.sv */
`timescale 1ns/1ps
// Function
// - Read messages: device transmits the operand byte
// - One operand per instruction, key takes eight
// - Transmit only while sending read operands
// - Parity, frame, break, collision enter error state
// - Error state ignores traffic until a break
// - Indirect load, optional pointer post-increment
// - Indirect store, optional pointer post-increment
// - Pointer store picks byte by opcode bit
// - I/O read at six-bit opcode address
// - I/O write at six-bit opcode address
// - Control space read at low-nibble address
// - Control space write at low-nibble address
// - Key instruction collects eight bytes, compares
// - Memory programming off until correct key
// - Writing zero to enable flag disables programming
// - Start, eight LSB-first bits, even parity, two stops
// - Break is twelve or more low bits
// - Guard time plus two idle bits before transmit
// - Enable flag reads set while programming enabled
module plac_top #(
  parameter logic [7:0] IDENT_CODE = plac_pkg::IDENT_DEFAULT,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic LINK_CLK,
  input wire logic LINK_DATA_I,
  output logic LINK_DATA_O,
  output logic LINK_DATA_OE,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_IO,
  output logic [plac_pkg::PTR_W-1:0] MEM_ADDR,
  output logic [plac_pkg::DATA_W-1:0] MEM_WDATA,
  input wire logic [plac_pkg::DATA_W-1:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic NVM_PROG_EN,
  output logic PHY_TX_MODE,
  output logic LINK_ERROR
);
  import plac_pkg::*;
  // IDENT_CODE default is an arbitrary neutral value

  function automatic plac_class_t classify(input logic [7:0] b);
    if ((b & OP_IO_MARK) != 8'h00) begin
      classify = b[OP_DIR_BIT] ? CL_WRITE : CL_READ;
    end else if ((b & OP_INC_MASK) == OP_LD ||
                 (b & OP_NIB_MASK) == OP_CSS_RD) begin
      classify = CL_READ;
    end else if ((b & OP_INC_MASK) == OP_ST ||
                 (b & OP_PTR_MASK) == OP_PTR ||
                 (b & OP_NIB_MASK) == OP_CSS_WR) begin
      classify = CL_WRITE;
    end else if (b == OP_KEY) begin
      classify = CL_KEY;
    end else begin
      classify = CL_NONE;
    end
  endfunction

  // Link pins are asynchronous to MCLK: two stages before use
  logic clk_s1_reg, clk_s2_reg, clk_s3_reg, dat_s1_reg, dat_s2_reg;
  logic rise, fall, din;
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      // Link clock idles high: a low reset value would fake a rising edge
      clk_s1_reg <= 1'b1;
      clk_s2_reg <= 1'b1;
      clk_s3_reg <= 1'b1;
      dat_s1_reg <= 1'b1;
      dat_s2_reg <= 1'b1;
    end else begin
      clk_s1_reg <= LINK_CLK;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      dat_s1_reg <= LINK_DATA_I;
      dat_s2_reg <= dat_s1_reg;
    end
  end
  assign rise = clk_s2_reg && !clk_s3_reg;
  assign fall = !clk_s2_reg && clk_s3_reg;
  assign din = dat_s2_reg;

  plac_state_t state_reg, state_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic [10:0] rx_sh_reg, rx_sh_next;
  logic armed_reg, armed_next;
  logic tx_act_reg, tx_act_next, prev_reg, prev_next;
  logic [7:0] tx_cnt_reg, tx_cnt_next, idle_len;
  logic [11:0] tx_sh_reg, tx_sh_next;
  logic out_reg, out_next, oe_reg, oe_next, bit_now;
  logic rx_good, brk, rx_bad, coll, tx_done, exc, overrun;
  logic f_in_ready, f_valid, pop, txgo_reg, txgo_next;
  logic [7:0] f_data, txb_reg, txb_next;
  logic [2:0] gt_reg, gt_next;

  // Fewer guard bits shorten each read; the code halves it per step, GT_NONE drops it
  assign idle_len = ((gt_reg == GT_NONE) ? 8'h00 : (GUARD_MAX_BITS >> gt_reg))
                    + IDLE_MIN_BITS;

  always_comb begin
    rx_cnt_next = rx_cnt_reg;
    rx_sh_next = rx_sh_reg;
    armed_next = armed_reg;
    tx_act_next = tx_act_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_sh_next = tx_sh_reg;
    prev_next = prev_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    rx_good = 1'b0;
    brk = 1'b0;
    rx_bad = 1'b0;
    coll = 1'b0;
    tx_done = 1'b0;
    bit_now = (tx_cnt_reg < idle_len) ? 1'b1 : tx_sh_reg[0];
    if (txgo_reg) begin
      tx_act_next = 1'b1;
      tx_cnt_next = 8'h00;
      prev_next = 1'b0;
      tx_sh_next = {2'b11, ^txb_reg, txb_reg, 1'b0};
      rx_cnt_next = 4'h0;
      armed_next = 1'b0;
    end else if (tx_act_reg) begin
      if (rise && !oe_reg && !din) begin
        coll = 1'b1;
        tx_act_next = 1'b0;
        oe_next = 1'b0;
        out_next = 1'b1;
      end else if (fall) begin
        if (tx_cnt_reg == idle_len + TX_FRAME_BITS) begin
          tx_done = 1'b1;
          tx_act_next = 1'b0;
          oe_next = 1'b0;
          out_next = 1'b1;
        end else begin
          out_next = bit_now;
          // Ones are driven for one bit only, then held by the pull-up
          oe_next = !bit_now || !prev_reg;
          prev_next = bit_now;
          tx_cnt_next = tx_cnt_reg + 8'h01;
          if (tx_cnt_reg >= idle_len) begin
            tx_sh_next = {1'b1, tx_sh_reg[11:1]};
          end
        end
      end
    end else if (rise) begin
      if (rx_cnt_reg == 4'h0) begin
        // A long break stays low: wait for high before a new start
        if (!din && armed_reg) begin
          rx_cnt_next = RX_FIRST_BIT;
          armed_next = 1'b0;
        end else if (din) begin
          armed_next = 1'b1;
        end
      end else begin
        rx_sh_next = {din, rx_sh_reg[10:1]};
        rx_cnt_next = rx_cnt_reg + 4'h1;
        if (rx_cnt_reg == RX_LAST_BIT) begin
          rx_cnt_next = 4'h0;
          armed_next = din;
          if (rx_sh_next == 11'h000) begin
            brk = 1'b1;
          end else if (!rx_sh_next[STOP1_POS] || !rx_sh_next[STOP2_POS] ||
                       rx_sh_next[PAR_POS] != ^rx_sh_next[7:0]) begin
            rx_bad = 1'b1;
          end else begin
            rx_good = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rx_cnt_reg <= 4'h0;
      rx_sh_reg <= 11'h000;
      armed_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      tx_cnt_reg <= 8'h00;
      tx_sh_reg <= 12'h000;
      prev_reg <= 1'b0;
      out_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else begin
      rx_cnt_reg <= rx_cnt_next;
      rx_sh_reg <= rx_sh_next;
      armed_reg <= armed_next;
      tx_act_reg <= tx_act_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_sh_reg <= tx_sh_next;
      prev_reg <= prev_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
    end
  end
  assign LINK_DATA_O = out_reg;
  assign LINK_DATA_OE = oe_reg;
  assign PHY_TX_MODE = tx_act_reg;

  // Received bytes queue here while the core waits on memory
  plac_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(MCLK),
    .rst_n(RST_N),
    .clr(exc),
    .in_valid(rx_good && state_reg != ST_ERR),
    .in_ready(f_in_ready),
    .in_data(rx_sh_reg[8:1]),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );
  // A programmer cannot be stalled mid-frame, so a full queue is an error
  assign overrun = rx_good && state_reg != ST_ERR && !f_in_ready;
  assign exc = state_reg != ST_ERR &&
               (brk || rx_bad || coll || overrun);

  logic [7:0] op_reg, op_next, wdata_reg, wdata_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next, addr_reg, addr_next;
  logic [KEY_W-1:0] key_reg, key_next, key_cand;
  logic [2:0] kcnt_reg, kcnt_next;
  logic nvm_reg, nvm_next, req_reg, req_next, we_reg, we_next;
  logic io_reg, io_next, is_css, is_io, post_inc;
  logic [7:0] css_val;

  assign is_css = (op_reg & OP_NIB_MASK) == OP_CSS_RD ||
                  (op_reg & OP_NIB_MASK) == OP_CSS_WR;
  assign is_io = (op_reg & OP_IO_MARK) != 8'h00;
  assign post_inc = op_reg == OP_LD_INC || op_reg == OP_ST_INC;
  assign key_cand = {f_data, key_reg[KEY_W-1:DATA_W]};

  always_comb begin
    css_val = 8'h00;
    case (op_reg[3:0])
      CSS_STATUS: css_val[NVM_EN_POS] = nvm_reg;
      CSS_PHYCTL: css_val[2:0] = gt_reg;
      CSS_IDENT: css_val = IDENT_CODE;
      default: css_val = 8'h00;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    ptr_next = ptr_reg;
    key_next = key_reg;
    kcnt_next = kcnt_reg;
    nvm_next = nvm_reg;
    gt_next = gt_reg;
    req_next = 1'b0;
    we_next = we_reg;
    io_next = io_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    txb_next = txb_reg;
    txgo_next = 1'b0;
    pop = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (f_valid) begin
          pop = 1'b1;
          op_next = f_data;
          case (classify(f_data))
            CL_READ: state_next = ST_FETCH;
            CL_WRITE: state_next = ST_OPER;
            CL_KEY: begin
              state_next = ST_KEY;
              kcnt_next = 3'h0;
            end
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_FETCH: begin
        if (is_css) begin
          txb_next = css_val;
          txgo_next = 1'b1;
          state_next = ST_TX;
        end else begin
          req_next = 1'b1;
          we_next = 1'b0;
          io_next = is_io;
          addr_next = is_io ? PTR_W'({op_reg[6:5], op_reg[3:0]}) : ptr_reg;
          state_next = ST_MEMR;
        end
      end
      ST_MEMR: begin
        if (MEM_ACK) begin
          txb_next = MEM_RDATA;
          txgo_next = 1'b1;
          if (post_inc) begin
            ptr_next = ptr_reg + 1'b1;
          end
          state_next = ST_TX;
        end
      end
      ST_TX: begin
        if (tx_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_OPER: begin
        if (f_valid) begin
          pop = 1'b1;
          state_next = ST_IDLE;
          if ((op_reg & OP_NIB_MASK) == OP_CSS_WR) begin
            if (op_reg[3:0] == CSS_STATUS && !f_data[NVM_EN_POS]) begin
              nvm_next = 1'b0;
            end
            if (op_reg[3:0] == CSS_PHYCTL) begin
              gt_next = f_data[2:0];
            end
          end else if ((op_reg & OP_PTR_MASK) == OP_PTR) begin
            if (op_reg[PTR_SEL_BIT]) begin
              ptr_next[PTR_W-1:DATA_W] = f_data;
            end else begin
              ptr_next[DATA_W-1:0] = f_data;
            end
          end else begin
            req_next = 1'b1;
            we_next = 1'b1;
            io_next = is_io;
            addr_next = is_io ? PTR_W'({op_reg[6:5], op_reg[3:0]}) : ptr_reg;
            wdata_next = f_data;
            state_next = ST_MEMW;
          end
        end
      end
      ST_MEMW: begin
        if (MEM_ACK) begin
          if (post_inc) begin
            ptr_next = ptr_reg + 1'b1;
          end
          state_next = ST_IDLE;
        end
      end
      ST_KEY: begin
        if (f_valid) begin
          pop = 1'b1;
          key_next = key_cand;
          kcnt_next = kcnt_reg + 3'h1;
          if (kcnt_reg == 3'(KEY_BYTES - 1)) begin
            state_next = ST_IDLE;
            if (key_cand == UNLOCK_KEY) begin
              nvm_next = 1'b1;
            end
          end
        end
      end
      ST_ERR: begin
        if (brk) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_ERR;
    endcase
    if (exc) begin
      state_next = ST_ERR;
      pop = 1'b0;
      req_next = 1'b0;
      txgo_next = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state_reg <= ST_IDLE;
      op_reg <= 8'h00;
      ptr_reg <= '0;
      key_reg <= '0;
      kcnt_reg <= 3'h0;
      nvm_reg <= 1'b0;
      gt_reg <= GT_RESET;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      io_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= 8'h00;
      txb_reg <= 8'h00;
      txgo_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      ptr_reg <= ptr_next;
      key_reg <= key_next;
      kcnt_reg <= kcnt_next;
      nvm_reg <= nvm_next;
      gt_reg <= gt_next;
      req_reg <= req_next;
      we_reg <= we_next;
      io_reg <= io_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      txb_reg <= txb_next;
      txgo_reg <= txgo_next;
    end
  end
  assign MEM_REQ = req_reg;
  assign MEM_WE = we_reg;
  assign MEM_IO = io_reg;
  assign MEM_ADDR = addr_reg;
  assign MEM_WDATA = wdata_reg;
  assign NVM_PROG_EN = nvm_reg;
  assign LINK_ERROR = state_reg[ST_ERR_POS];

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  AST_DRIVE_ONLY_TX: assert property (
    LINK_DATA_OE |-> (state_reg == ST_TX && tx_act_reg))
    else $error("Link driven outside a read answer");
  AST_EXC_TO_ERR: assert property (
    (state_reg != ST_ERR && (rx_bad || coll || brk)) |=> LINK_ERROR)
    else $error("Exception did not enter error state");
  AST_ERR_HOLD: assert property (
    (LINK_ERROR && !brk) |=> (LINK_ERROR && !MEM_REQ && !txgo_reg))
    else $error("Error state left without a break");
  AST_PTR_INC: assert property (
    ((state_reg == ST_MEMR || state_reg == ST_MEMW) && MEM_ACK && !exc
     && post_inc) |=> ptr_reg == PTR_W'($past(ptr_reg) + 1'b1))
    else $error("Pointer post-increment wrong");
  AST_PTR_STORE: assert property (
    (state_reg == ST_OPER && f_valid && !exc && op_reg == OP_PTR)
    |=> ptr_reg[DATA_W-1:0] == $past(f_data) &&
        ptr_reg[PTR_W-1:DATA_W] == $past(ptr_reg[PTR_W-1:DATA_W]))
    else $error("Pointer low byte store wrong");
  AST_KEY_ENABLE: assert property (
    (state_reg == ST_KEY && f_valid && !exc && key_cand == UNLOCK_KEY
     && kcnt_reg == 3'(KEY_BYTES - 1)) |=> NVM_PROG_EN)
    else $error("Correct key did not enable programming");
  AST_NVM_CLEAR: assert property (
    (state_reg == ST_OPER && f_valid && !exc && op_reg == OP_CSS_WR
     && !f_data[NVM_EN_POS]) |=> !NVM_PROG_EN)
    else $error("Writing zero did not disable programming");
  AST_GUARD_IDLE: assert property (
    (tx_act_reg && tx_cnt_reg != 8'h00 && tx_cnt_reg <= idle_len)
    |-> LINK_DATA_O)
    else $error("Start bit sent inside guard time");
  AST_UNDEF_IGNORE: assert property (
    (state_reg == ST_IDLE && f_valid && !exc &&
     classify(f_data) == CL_NONE)
    |=> (state_reg == ST_IDLE && $stable(ptr_reg) && !MEM_REQ)[*2])
    else $error("Undefined opcode had an effect");
endmodule

/* File: hdl/plac_pkg.sv */
package plac_pkg;
  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam int KEY_BYTES = 8;
  localparam int KEY_W = 64;
  localparam logic [KEY_W-1:0] UNLOCK_KEY = 64'h1289AB45CDD888FF;
  // Bits received after the start bit: data, parity, two stops
  localparam logic [3:0] RX_LAST_BIT = 4'hB;
  localparam logic [3:0] RX_FIRST_BIT = 4'h1;
  localparam int PAR_POS = 8;
  localparam int STOP1_POS = 9;
  localparam int STOP2_POS = 10;
  localparam logic [7:0] TX_FRAME_BITS = 8'h0C;
  localparam logic [7:0] IDLE_MIN_BITS = 8'h02;
  localparam logic [7:0] GUARD_MAX_BITS = 8'h80;
  localparam logic [2:0] GT_RESET = 3'h0;
  localparam logic [2:0] GT_NONE = 3'h7;
  // Opcodes and match masks
  localparam logic [7:0] OP_LD = 8'h20;
  localparam logic [7:0] OP_LD_INC = 8'h24;
  localparam logic [7:0] OP_ST = 8'h60;
  localparam logic [7:0] OP_ST_INC = 8'h64;
  localparam logic [7:0] OP_INC_MASK = 8'hFB;
  localparam logic [7:0] OP_PTR = 8'h68;
  localparam logic [7:0] OP_PTR_MASK = 8'hFE;
  localparam logic [7:0] OP_IO_MARK = 8'h10;
  localparam int OP_DIR_BIT = 7;
  localparam logic [7:0] OP_NIB_MASK = 8'hF0;
  localparam logic [7:0] OP_CSS_RD = 8'h80;
  localparam logic [7:0] OP_CSS_WR = 8'hC0;
  localparam logic [7:0] OP_KEY = 8'hE0;
  localparam int PTR_SEL_BIT = 0;
  // Control-and-status space
  localparam logic [3:0] CSS_STATUS = 4'h0;
  localparam logic [3:0] CSS_PHYCTL = 4'h2;
  localparam logic [3:0] CSS_IDENT = 4'hF;
  localparam int NVM_EN_POS = 1;
  localparam logic [7:0] IDENT_DEFAULT = 8'h5A;
  // Error state has its own bit so the error pin is a bare flop
  localparam int ST_ERR_POS = 7;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_FETCH = 8'h02,
    ST_MEMR = 8'h04,
    ST_TX = 8'h08,
    ST_OPER = 8'h10,
    ST_MEMW = 8'h20,
    ST_KEY = 8'h40,
    ST_ERR = 8'h80
  } plac_state_t;
  typedef enum logic [1:0] {
    CL_NONE  = 2'h0,
    CL_READ  = 2'h1,
    CL_WRITE = 2'h2,
    CL_KEY   = 2'h3
  } plac_class_t;
endpackage

/* File: hdl/plac_fifo.sv */
`timescale 1ns/1ps
module plac_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic do_wr, do_rd;

  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign do_wr = in_valid && in_ready && !clr;
  assign do_rd = out_valid && out_ready && !clr;

  always_comb begin
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (clr) begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end else begin
      if (do_wr) begin
        wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_next = cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; only the pointers and count define validity
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
endmodule

/* File: sim/plac_prog_model.sv */
`timescale 1ns/1ps
module plac_prog_model (
  input wire logic mclk,
  input wire logic line,
  output logic link_clk,
  output logic drv_oe,
  output logic drv_o
);
  logic [11:0] rxf;
  event got;
  // Link clock stands high between frames
  initial begin
    link_clk = 1'b1;
    drv_oe = 1'b0;
    drv_o = 1'b1;
  end
  task automatic hp();
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // Read late in the high phase to allow for the device's synchroniser
  task automatic bit_io(input logic oe, input logic v, output logic s);
    link_clk = 1'b0;
    drv_oe = oe;
    drv_o = v;
    hp();
    link_clk = 1'b1;
    hp();
    s = line;
  endtask
  task automatic send(input logic [7:0] b, input logic bad);
    logic [11:0] f;
    logic s;
    f = {2'b11, ^b ^ bad, b, 1'b0};
    // Drive is left on; the next bit releases it, never twice in one step
    for (int i = 0; i < 12; i++) bit_io(1'b1, f[i], s);
  endtask
  task automatic idle(input int n);
    logic s;
    repeat (n) bit_io(1'b0, 1'b1, s);
  endtask
  task automatic brk();
    logic s;
    repeat (14) bit_io(1'b1, 1'b0, s);
  endtask
  // Bounded wait for a start bit; collide pulls the stop bits low
  task automatic recv(input logic collide, output logic ok, output int w);
    logic s;
    ok = 1'b0;
    w = 0;
    rxf = 12'h000;
    while (ok !== 1'b1 && w < 400) begin
      bit_io(1'b0, 1'b1, s);
      if (s === 1'b0) ok = 1'b1;
      else w++;
    end
    for (int i = 1; i < 12; i++) begin
      bit_io(collide && i > 9, 1'b0, s);
      rxf[i] = s;
    end
    if (ok === 1'b1 && !collide) -> got;
  endtask
endmodule

/* File: sim/prog_link_access_layer_tb.sv */
`timescale 1ns/1ps
module prog_link_access_layer_tb;
  import plac_pkg::*;
  logic mclk, rst_n, link_clk, line, drv_oe, drv_o, mem_ack, ok;
  logic link_data_o, link_data_oe, mem_req, mem_we, mem_io;
  logic nvm_prog_en, phy_tx_mode, link_error;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, d;
  logic [5:0] a;
  logic [25:0] mq[$];
  logic [11:0] aq[$];
  int failures, n_tests, wn, w;
  // Pull-up holds the wire high when nobody drives it
  assign line = link_data_oe ? link_data_o : (drv_oe ? drv_o : 1'b1);
  plac_top i_dut (
    .MCLK(mclk),
    .RST_N(rst_n),
    .LINK_CLK(link_clk),
    .LINK_DATA_I(line),
    .LINK_DATA_O(link_data_o),
    .LINK_DATA_OE(link_data_oe),
    .MEM_REQ(mem_req),
    .MEM_WE(mem_we),
    .MEM_IO(mem_io),
    .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata),
    .MEM_RDATA(mem_rdata),
    .MEM_ACK(mem_ack),
    .NVM_PROG_EN(nvm_prog_en),
    .PHY_TX_MODE(phy_tx_mode),
    .LINK_ERROR(link_error)
  );
  plac_prog_model u_prog (
    .mclk(mclk),
    .line(line),
    .link_clk(link_clk),
    .drv_oe(drv_oe),
    .drv_o(drv_o)
  );
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  function automatic logic [7:0] rd_of(input logic [15:0] ad, input logic io);
    return ad[7:0] ^ ad[15:8] ^ (io ? 8'h3C : 8'hC3);
  endfunction
  task automatic chk_mem(input string n, input logic [25:0] e, g);
    n_tests++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_frm(input string n, input logic [11:0] e, g);
    n_tests++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_flag(input string n, input logic e, g);
    n_tests++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Memory side: random latency, data that moves every idle cycle
  always @(posedge mclk) begin
    #1;
    mem_ack = 1'b0;
    mem_rdata = ~mem_rdata;
    if (mem_req === 1'b1) wn = 1 + ($urandom % 4);
    else if (wn > 0) begin
      wn--;
      if (wn == 0) begin
        mem_ack = 1'b1;
        mem_rdata = rd_of(mem_addr, mem_io);
      end
    end
  end
  always @(posedge mclk) begin
    #2;
    if (mem_req === 1'b1)
      chk_mem("mem_req", mq.size() > 0 ? mq.pop_front() : 26'bx,
        {mem_we, mem_io, mem_addr, mem_we ? mem_wdata : 8'h00});
  end
  always @(u_prog.got)
    chk_frm("answer", aq.size() > 0 ? aq.pop_front() : 12'bx,
      u_prog.rxf);
  task automatic rd(input logic [7:0] op, input logic [7:0] e);
    aq.push_back({2'b11, ^e, e, 1'b0});
    u_prog.send(op, 1'b0);
    u_prog.recv(1'b0, ok, w);
    if (ok !== 1'b1) begin
      failures++;
      close_out();
    end else begin
      u_prog.idle(2);
      chk_flag("tx_mode", 1'b0, phy_tx_mode);
    end
  endtask
  task automatic mrd(input logic [7:0] op, input logic [15:0] ad,
      input logic io);
    mq.push_back({1'b0, io, ad, 8'h00});
    rd(op, rd_of(ad, io));
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] dv);
    u_prog.send(op, 1'b0);
    u_prog.send(dv, 1'b0);
    u_prog.idle(2);
  endtask
  task automatic mwr(input logic [7:0] op, input logic [15:0] ad,
      input logic io, input logic [7:0] dv);
    mq.push_back({1'b1, io, ad, dv});
    wr(op, dv);
  endtask
  task automatic key(input logic [63:0] k);
    u_prog.send(8'hE0, 1'b0);
    for (int i = 0; i < 8; i++) u_prog.send(k[8*i +: 8], 1'b0);
    u_prog.idle(2);
  endtask
  initial begin
    rst_n = 1'b0;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    wn = 0;
    failures = 0;
    n_tests = 0;
    void'($urandom(32'hAEB8));
    repeat (12) @(posedge mclk);
    #1 rst_n = 1'b1;
    chk_flag("nvm_en", 1'b0, nvm_prog_en);
    u_prog.idle(16);
    rd(8'h82, 8'h00);
    chk_flag("guard_long", 1'b1, w >= 130);
    wr(8'hC2, 8'h07);
    rd(8'h82, 8'h07);
    chk_flag("guard_short", 1'b1, w < 8);
    rd(8'h8F, IDENT_DEFAULT);
    wr(8'h68, 8'hFF);
    wr(8'h69, 8'h12);
    mrd(8'h24, 16'h12FF, 1'b0);
    mrd(8'h20, 16'h1300, 1'b0);
    mrd(8'h20, 16'h1300, 1'b0);
    d = 8'($urandom);
    mwr(8'h64, 16'h1300, 1'b0, d);
    mwr(8'h60, 16'h1301, 1'b0, ~d);
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
      mrd({1'b0, a[5:4], 1'b1, a[3:0]}, {10'h000, a}, 1'b1);
      mwr({1'b1, a[5:4], 1'b1, a[3:0]}, {10'h000, a}, 1'b1, 8'($urandom));
    end
    for (int i = 0; i < 5; i++)
      u_prog.send(8'(40'h0040A0E82C >> (8*i)), 1'b0);
    u_prog.idle(4);
    mrd(8'h20, 16'h1301, 1'b0);
    key(64'h1289AB45CDD888FE);
    chk_flag("nvm_en", 1'b0, nvm_prog_en);
    rd(8'h80, 8'h00);
    key(64'h1289AB45CDD888FF);
    chk_flag("nvm_en", 1'b1, nvm_prog_en);
    rd(8'h80, 8'h02);
    wr(8'hC0, 8'h00);
    chk_flag("nvm_en", 1'b0, nvm_prog_en);
    // Writing a one to the enable flag must not turn it back on
    wr(8'hC0, 8'h02);
    rd(8'h80, 8'h00);
    u_prog.send(8'h82, 1'b1);
    u_prog.idle(2);
    chk_flag("error", 1'b1, link_error);
    u_prog.send(8'h82, 1'b0);
    u_prog.idle(20);
    chk_flag("tx_mode", 1'b0, phy_tx_mode);
    u_prog.brk();
    u_prog.idle(2);
    chk_flag("error", 1'b0, link_error);
    rd(8'h82, 8'h07);
    u_prog.send(8'h8F, 1'b0);
    u_prog.recv(1'b1, ok, w);
    u_prog.idle(2);
    chk_flag("error", 1'b1, link_error);
    chk_flag("drive_en", 1'b0, link_data_oe);
    u_prog.brk();
    u_prog.idle(2);
    u_prog.brk();
    u_prog.idle(2);
    u_prog.brk();
    u_prog.idle(2);
    chk_flag("error", 1'b0, link_error);
    rd(8'h8F, IDENT_DEFAULT);
    chk_flag("queues_empty", 1'b1, mq.size() == 0 && aq.size() == 0);
    close_out();
  end
endmodule
